// ==== axev_bank.sv ====
// axis event enable, counter latch and extension status register bank on apb
//
// Function
// - enabled events raise the event interrupt
// - bit0 normal stop, bit1 next start
// - bit2 op prereg write, bit3 cmp5 prereg
// - bits4-7 accel/decel begin and finish
// - bits8-12 comparators one to five
// - bits13-15 clear, latch pin, origin latch
// - bits16-18 slowdown, drive change, start
// - latch triggers copy all counters
// - position and general latches signed 32-bit read-only
// - select bit picks deflection or speed
// - stopped axis latches zero speed
// - upper bits sign-extend or read zero
// - deflection signed 16, speed unsigned 16
// - unused bits ignore writes, read zero
// - sign bits ignore writes, mirror top bit
// - extension status layout, top byte zero
// - four-bit operation state codes
// - direction bit zero positive one negative
`timescale 1ns/100ps
`default_nettype none
module axev_bank
    import axev_pkg::*;
(
    input wire logic REF_CLK_I,
    input wire logic SYS_RST_I,
    input wire logic CLK_EN_I,
    input wire logic PSEL_I,
    input wire logic PENABLE_I,
    input wire logic PWRITE_I,
    input wire logic [7:0] PADDR_I,
    input wire logic [31:0] PWDATA_I,
    output logic [31:0] PRDATA_O,
    output logic PREADY_O,
    output logic PSLVERR_O,
    input wire logic [18:0] EVENT_PULSE_I,
    input wire logic LATCH_TRIGGER_INPUT_I,
    input wire logic ORIGIN_INPUT_I,
    input wire logic LATCH_COMMAND_I,
    input wire logic [31:0] COMMAND_POSITION_COUNTER_I,
    input wire logic [31:0] MECHANICAL_POSITION_COUNTER_I,
    input wire logic [15:0] DEFLECTION_COUNTER_I,
    input wire logic [15:0] CURRENT_SPEED_I,
    input wire logic AXIS_MOVING_I,
    input wire logic [31:0] GENERAL_PURPOSE_COUNTER_I,
    input wire logic [3:0] OPERATION_STATE_CODE_I,
    input wire logic DIRECTION_STATUS_I,
    input wire logic [12:0] INPUT_MONITOR_I,
    input wire logic [1:0] CMP5_PREREG_MONITOR_I,
    input wire logic [1:0] OP_PREREG_MONITOR_I,
    input wire logic PLUS_SLOWDOWN_LATCHED_I,
    input wire logic MINUS_SLOWDOWN_LATCHED_I,
    output logic EVENT_IRQ_O,
    output logic [18:0] EVENT_CAUSE_O
);
    logic [31:0] evt_enable;
    logic [31:0] env_five;
    logic [31:0] cmd_latch;
    logic [31:0] mech_latch;
    logic [15:0] defl_latch;
    logic [31:0] gen_latch;
    logic latch_src;
    logic latch_fire;
    logic wr_en;
    logic addr_ok;
    logic [31:0] defl_read;
    logic [31:0] sts_read;
    logic [31:0] next_prdata;
    logic [18:0] next_cause;

    assign latch_src = env_five[AXEV_LATCH_SRC_BIT];
    assign latch_fire = LATCH_TRIGGER_INPUT_I | ORIGIN_INPUT_I | LATCH_COMMAND_I;
    assign wr_en = CLK_EN_I & PSEL_I & PENABLE_I & PWRITE_I;
    assign PREADY_O = 1'b1;

    always_comb begin
        case (PADDR_I)
            AXEV_OFS_EVT_ENABLE,
            AXEV_OFS_CMD_LATCH,
            AXEV_OFS_MECH_LATCH,
            AXEV_OFS_DEFL_LATCH,
            AXEV_OFS_GEN_LATCH,
            AXEV_OFS_EXT_STATUS,
            AXEV_OFS_ENV_FIVE: addr_ok = 1'b1;
            default: addr_ok = 1'b0;
        endcase
    end

    // writable registers, unused bits dropped
    always_ff @(posedge REF_CLK_I or posedge SYS_RST_I) begin
        if (SYS_RST_I) begin
            evt_enable <= AXEV_EVT_ENABLE_RST;
            env_five <= AXEV_ENV_FIVE_RST;
        end else if (wr_en) begin
            if (PADDR_I == AXEV_OFS_EVT_ENABLE) begin
                evt_enable <= PWDATA_I & AXEV_EVT_ENABLE_MASK;
            end
            if (PADDR_I == AXEV_OFS_ENV_FIVE) begin
                env_five <= PWDATA_I & AXEV_ENV_FIVE_MASK;
            end
        end
    end

    // counter latches
    always_ff @(posedge REF_CLK_I or posedge SYS_RST_I) begin
        if (SYS_RST_I) begin
            cmd_latch <= AXEV_LATCH_RST;
            mech_latch <= AXEV_LATCH_RST;
            defl_latch <= AXEV_LATCH_RST[15:0];
            gen_latch <= AXEV_LATCH_RST;
        end else if (CLK_EN_I && latch_fire) begin
            cmd_latch <= COMMAND_POSITION_COUNTER_I;
            mech_latch <= MECHANICAL_POSITION_COUNTER_I;
            gen_latch <= GENERAL_PURPOSE_COUNTER_I;
            if (!latch_src) begin
                defl_latch <= DEFLECTION_COUNTER_I;
            end else if (AXIS_MOVING_I) begin
                defl_latch <= CURRENT_SPEED_I;
            end else begin
                defl_latch <= 16'h0000;
            end
        end
    end

    // sign extension or zero fill of the third latch
    always_comb begin
        if (latch_src) begin
            defl_read = {16'h0000, defl_latch};
        end else begin
            defl_read = {{16{defl_latch[AXEV_DEFL_SIGN_BIT]}}, defl_latch};
        end
    end

    // extension status assembly
    always_comb begin
        sts_read = 32'h00000000;
        sts_read[3:0] = OPERATION_STATE_CODE_I;
        sts_read[AXEV_STS_DIR_BIT] = DIRECTION_STATUS_I;
        sts_read[AXEV_STS_INPUT_LSB +: 13] = INPUT_MONITOR_I;
        sts_read[AXEV_STS_PREREG_LSB +: 2] = CMP5_PREREG_MONITOR_I;
        sts_read[AXEV_STS_PREREG_LSB + 2 +: 2] = OP_PREREG_MONITOR_I;
        sts_read[AXEV_STS_SDL_LSB] = PLUS_SLOWDOWN_LATCHED_I;
        sts_read[AXEV_STS_SDL_LSB + 1] = MINUS_SLOWDOWN_LATCHED_I;
    end

    always_comb begin
        case (PADDR_I)
            AXEV_OFS_EVT_ENABLE: next_prdata = evt_enable;
            AXEV_OFS_CMD_LATCH: next_prdata = cmd_latch;
            AXEV_OFS_MECH_LATCH: next_prdata = mech_latch;
            AXEV_OFS_DEFL_LATCH: next_prdata = defl_read;
            AXEV_OFS_GEN_LATCH: next_prdata = gen_latch;
            AXEV_OFS_EXT_STATUS: next_prdata = sts_read;
            AXEV_OFS_ENV_FIVE: next_prdata = env_five;
            default: next_prdata = 32'h00000000;
        endcase
    end

    // read data registered in the setup phase, valid during access
    always_ff @(posedge REF_CLK_I or posedge SYS_RST_I) begin
        if (SYS_RST_I) begin
            PRDATA_O <= 32'h00000000;
        end else if (CLK_EN_I && PSEL_I && !PENABLE_I && !PWRITE_I) begin
            PRDATA_O <= next_prdata;
        end
    end

    assign PSLVERR_O = PSEL_I & PENABLE_I & ~addr_ok;

    // event gating, one registered cause pulse per enabled event
    assign next_cause = EVENT_PULSE_I & evt_enable[AXEV_EVT_COUNT-1:0];

    always_ff @(posedge REF_CLK_I or posedge SYS_RST_I) begin
        if (SYS_RST_I) begin
            EVENT_CAUSE_O <= 19'h00000;
            EVENT_IRQ_O <= 1'b0;
        end else if (CLK_EN_I) begin
            EVENT_CAUSE_O <= next_cause;
            EVENT_IRQ_O <= |next_cause;
        end
    end

    // event gate
    property p_irq_gate;
        @(posedge REF_CLK_I) disable iff (SYS_RST_I)
        CLK_EN_I
        |=> EVENT_IRQ_O == |($past(EVENT_PULSE_I) & $past(evt_enable[18:0]));
    endproperty
    a_irq_gate: assert property (p_irq_gate) else $error("event irq does not follow enabled events");

    property p_irq_idle;
        @(posedge REF_CLK_I) disable iff (SYS_RST_I)
        CLK_EN_I && ((EVENT_PULSE_I & evt_enable[18:0]) == 19'h00000)
        |=> !EVENT_IRQ_O;
    endproperty
    a_irq_idle: assert property (p_irq_idle) else $error("event irq without an enabled event");

    property p_cause_gate;
        @(posedge REF_CLK_I) disable iff (SYS_RST_I)
        CLK_EN_I
        |=> EVENT_CAUSE_O == ($past(EVENT_PULSE_I) & $past(evt_enable[18:0]));
    endproperty
    a_cause_gate: assert property (p_cause_gate) else $error("cause bits wrong");

    // writable registers
    property p_enable_write;
        @(posedge REF_CLK_I) disable iff (SYS_RST_I)
        wr_en && PADDR_I == AXEV_OFS_EVT_ENABLE
        |=> evt_enable == ($past(PWDATA_I) & AXEV_EVT_ENABLE_MASK);
    endproperty
    a_enable_write: assert property (p_enable_write) else $error("enable write not stored");

    property p_enable_top_zero;
        @(posedge REF_CLK_I) disable iff (SYS_RST_I)
        evt_enable[31:19] == 13'h0000;
    endproperty
    a_enable_top_zero: assert property (p_enable_top_zero) else $error("undefined enable bits stored");

    property p_env_five_write;
        @(posedge REF_CLK_I) disable iff (SYS_RST_I)
        wr_en && PADDR_I == AXEV_OFS_ENV_FIVE
        |=> latch_src == $past(PWDATA_I[AXEV_LATCH_SRC_BIT]);
    endproperty
    a_env_five_write: assert property (p_env_five_write) else $error("latch source select not stored");

    property p_env_five_zero;
        @(posedge REF_CLK_I) disable iff (SYS_RST_I)
        (env_five & ~AXEV_ENV_FIVE_MASK) == 32'h00000000;
    endproperty
    a_env_five_zero: assert property (p_env_five_zero) else $error("unused environment bits stored");

    // counter latches
    property p_latch_copy;
        @(posedge REF_CLK_I) disable iff (SYS_RST_I)
        CLK_EN_I && latch_fire
        |=> cmd_latch == $past(COMMAND_POSITION_COUNTER_I)
            && gen_latch == $past(GENERAL_PURPOSE_COUNTER_I);
    endproperty
    a_latch_copy: assert property (p_latch_copy) else $error("counters not latched on trigger");

    property p_mech_copy;
        @(posedge REF_CLK_I) disable iff (SYS_RST_I)
        CLK_EN_I && latch_fire
        |=> mech_latch == $past(MECHANICAL_POSITION_COUNTER_I);
    endproperty
    a_mech_copy: assert property (p_mech_copy) else $error("mechanical counter not latched");

    property p_latch_hold;
        @(posedge REF_CLK_I) disable iff (SYS_RST_I)
        !(CLK_EN_I && latch_fire)
        |=> $stable(mech_latch) && $stable(defl_latch);
    endproperty
    a_latch_hold: assert property (p_latch_hold) else $error("latch changed without trigger");

    property p_cmd_hold;
        @(posedge REF_CLK_I) disable iff (SYS_RST_I)
        !(CLK_EN_I && latch_fire)
        |=> $stable(cmd_latch) && $stable(gen_latch);
    endproperty
    a_cmd_hold: assert property (p_cmd_hold) else $error("position latch changed without trigger");

    property p_latch_readonly;
        @(posedge REF_CLK_I) disable iff (SYS_RST_I)
        wr_en && !latch_fire
        |=> $stable(cmd_latch) && $stable(mech_latch) && $stable(gen_latch);
    endproperty
    a_latch_readonly: assert property (p_latch_readonly) else $error("latch written over the bus");

    property p_frozen;
        @(posedge REF_CLK_I) disable iff (SYS_RST_I)
        !CLK_EN_I
        |=> $stable(evt_enable) && $stable(env_five) && $stable(cmd_latch) && $stable(PRDATA_O);
    endproperty
    a_frozen: assert property (p_frozen) else $error("state changed while clock enable low");

    property p_defl_pick;
        @(posedge REF_CLK_I) disable iff (SYS_RST_I)
        CLK_EN_I && latch_fire && !latch_src
        |=> defl_latch == $past(DEFLECTION_COUNTER_I);
    endproperty
    a_defl_pick: assert property (p_defl_pick) else $error("deflection not latched");

    property p_speed_pick;
        @(posedge REF_CLK_I) disable iff (SYS_RST_I)
        CLK_EN_I && latch_fire && latch_src && AXIS_MOVING_I
        |=> defl_latch == $past(CURRENT_SPEED_I);
    endproperty
    a_speed_pick: assert property (p_speed_pick) else $error("speed not latched");

    property p_speed_stop;
        @(posedge REF_CLK_I) disable iff (SYS_RST_I)
        CLK_EN_I && latch_fire && latch_src && !AXIS_MOVING_I
        |=> defl_latch == 16'h0000;
    endproperty
    a_speed_stop: assert property (p_speed_stop) else $error("stopped speed latch not zero");

    property p_defl_ext;
        @(posedge REF_CLK_I) disable iff (SYS_RST_I)
        latch_src ? defl_read[31:16] == 16'h0000 : defl_read[31:16] == {16{defl_latch[AXEV_DEFL_SIGN_BIT]}};
    endproperty
    a_defl_ext: assert property (p_defl_ext) else $error("third latch upper bits wrong");

    // read path
    property p_cmd_read;
        @(posedge REF_CLK_I) disable iff (SYS_RST_I)
        CLK_EN_I && PSEL_I && !PENABLE_I && !PWRITE_I && PADDR_I == AXEV_OFS_CMD_LATCH
        |=> PRDATA_O == $past(cmd_latch);
    endproperty
    a_cmd_read: assert property (p_cmd_read) else $error("position latch read wrong");

    property p_defl_read;
        @(posedge REF_CLK_I) disable iff (SYS_RST_I)
        CLK_EN_I && PSEL_I && !PENABLE_I && !PWRITE_I && PADDR_I == AXEV_OFS_DEFL_LATCH
        |=> PRDATA_O[15:0] == $past(defl_latch);
    endproperty
    a_defl_read: assert property (p_defl_read) else $error("third latch read wrong");

    property p_unmapped_read;
        @(posedge REF_CLK_I) disable iff (SYS_RST_I)
        CLK_EN_I && PSEL_I && !PENABLE_I && !PWRITE_I && !addr_ok
        |=> PRDATA_O == 32'h00000000;
    endproperty
    a_unmapped_read: assert property (p_unmapped_read) else $error("unmapped read not zero");

    // extension status
    property p_sts_top;
        @(posedge REF_CLK_I) disable iff (SYS_RST_I)
        sts_read[31:24] == 8'h00 && sts_read[AXEV_STS_DIR_BIT] == DIRECTION_STATUS_I;
    endproperty
    a_sts_top: assert property (p_sts_top) else $error("status layout wrong");

    property p_sts_code;
        @(posedge REF_CLK_I) disable iff (SYS_RST_I)
        sts_read[3:0] == OPERATION_STATE_CODE_I;
    endproperty
    a_sts_code: assert property (p_sts_code) else $error("operation state code misplaced");

    property p_sts_fields;
        @(posedge REF_CLK_I) disable iff (SYS_RST_I)
        sts_read[AXEV_STS_INPUT_LSB +: 13] == INPUT_MONITOR_I
            && sts_read[21:18] == {OP_PREREG_MONITOR_I, CMP5_PREREG_MONITOR_I}
            && sts_read[23:22] == {MINUS_SLOWDOWN_LATCHED_I, PLUS_SLOWDOWN_LATCHED_I};
    endproperty
    a_sts_fields: assert property (p_sts_fields) else $error("status monitor fields misplaced");
endmodule
`default_nettype wire

// ==== axev_pkg.sv ====
// package: offsets, field positions and reset values of the axis event/latch/status bank
package axev_pkg;
    localparam logic [7:0] AXEV_OFS_EVT_ENABLE = 8'h00;
    localparam logic [7:0] AXEV_OFS_CMD_LATCH = 8'h04;
    localparam logic [7:0] AXEV_OFS_MECH_LATCH = 8'h08;
    localparam logic [7:0] AXEV_OFS_DEFL_LATCH = 8'h0c;
    localparam logic [7:0] AXEV_OFS_GEN_LATCH = 8'h10;
    localparam logic [7:0] AXEV_OFS_EXT_STATUS = 8'h14;
    localparam logic [7:0] AXEV_OFS_ENV_FIVE = 8'h18;
    localparam int AXEV_EVT_COUNT = 19;
    localparam logic [31:0] AXEV_EVT_ENABLE_MASK = 32'h0007ffff;
    localparam logic [31:0] AXEV_EVT_ENABLE_RST = 32'h00000000;
    localparam int AXEV_LATCH_SRC_BIT = 14;
    localparam logic [31:0] AXEV_ENV_FIVE_MASK = 32'h00004000;
    localparam logic [31:0] AXEV_ENV_FIVE_RST = 32'h00000000;
    localparam logic [31:0] AXEV_LATCH_RST = 32'h00000000;
    localparam int AXEV_DEFL_SIGN_BIT = 15;
    localparam int AXEV_STS_DIR_BIT = 4;
    localparam int AXEV_STS_INPUT_LSB = 5;
    localparam int AXEV_STS_PREREG_LSB = 18;
    localparam int AXEV_STS_SDL_LSB = 22;
    typedef enum logic [3:0] {
        AXEV_OP_STOPPED = 4'b0000,
        AXEV_OP_WAIT_DRIVE = 4'b0001,
        AXEV_OP_WAIT_START = 4'b0010,
        AXEV_OP_WAIT_SYNC = 4'b0011,
        AXEV_OP_WAIT_AXIS = 4'b0100,
        AXEV_OP_WAIT_DEVCLR = 4'b0101,
        AXEV_OP_WAIT_DIRCHG = 4'b0110,
        AXEV_OP_BACKLASH = 4'b0111
    } axev_op_state_t;
endpackage

// ==== test_axis_event_enable_latch_status.sv ====
// self-checking bench for the axis event, latch and status register bank
`timescale 1ns/100ps
`default_nettype none
module test_axis_event_enable_latch_status import axev_pkg::*;;
    logic clk = 0, rst = 1, psel = 0, penable = 0, pwrite = 0, pready, err, clken = 1, serr;
    logic latch_trigger_input = 0, origin_input = 0, lcmd = 0, moving = 0, dir = 0, plus_slowdown_latched = 0, minus_slowdown_latched = 0, irq;
    logic [7:0] paddr = '0;
    logic [31:0] pwdata = '0, prdata, rd, en, cmd = '0, mech = '0, gen = '0;
    logic [31:0] expq [4];
    logic [18:0] ev = '0, cause, pat;
    logic [15:0] defl = '0, spd = '0;
    logic [3:0] op = '0;
    logic [12:0] mon = '0;
    logic [1:0] pfc = '0, pfm = '0;
    int mismatches = 0, checks_done = 0;
    always #25 clk = ~clk;
    axev_bank dut_u (.REF_CLK_I(clk), .SYS_RST_I(rst), .CLK_EN_I(clken), .PSEL_I(psel),
        .PENABLE_I(penable), .PWRITE_I(pwrite), .PADDR_I(paddr), .PWDATA_I(pwdata),
        .PRDATA_O(prdata), .PREADY_O(pready), .PSLVERR_O(err), .EVENT_PULSE_I(ev),
        .LATCH_TRIGGER_INPUT_I(latch_trigger_input), .ORIGIN_INPUT_I(origin_input), .LATCH_COMMAND_I(lcmd),
        .COMMAND_POSITION_COUNTER_I(cmd), .MECHANICAL_POSITION_COUNTER_I(mech),
        .DEFLECTION_COUNTER_I(defl), .CURRENT_SPEED_I(spd), .AXIS_MOVING_I(moving),
        .GENERAL_PURPOSE_COUNTER_I(gen), .OPERATION_STATE_CODE_I(op), .DIRECTION_STATUS_I(dir),
        .INPUT_MONITOR_I(mon), .CMP5_PREREG_MONITOR_I(pfc), .OP_PREREG_MONITOR_I(pfm),
        .PLUS_SLOWDOWN_LATCHED_I(plus_slowdown_latched), .MINUS_SLOWDOWN_LATCHED_I(minus_slowdown_latched),
        .EVENT_IRQ_O(irq), .EVENT_CAUSE_O(cause));
    task chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        checks_done++;
        if (got !== exp) begin
            mismatches++;
            $display("ERROR %s expected %h seen %h", name, exp, got);
        end
    endtask
    // one apb transfer, then one idle cycle
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do begin
            @(posedge clk);
        end while (pready !== 1'b1);
        rd = prdata;
        serr = err;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk);
    endtask
    function automatic logic [31:0] defl_exp(input int t, input logic [15:0] d, input logic [15:0] s);
        if (t == 3) return {16'h0000, s};
        if (t == 4) return 32'h00000000;
        return {{16{d[15]}}, d};
    endfunction
    task test_done();
        $display("checks %0d mismatches %0d", checks_done, mismatches);
        if (mismatches == 0 && checks_done > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    initial begin
        repeat (5000) @(posedge clk);
        mismatches++;
        test_done();
    end
    initial begin
        void'($urandom(32'h6b1d52c7));
        repeat (4) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        for (int i = 0; i < 7; i++) begin
            apb(1'b0, 8'(4 * i), '0);
            chk("reset value", 32'h00000000, rd);
            chk("mapped error", 32'h00000000, 32'(serr));
        end
        $display("test reset done");
        for (int k = 0; k < 2; k++) begin
            en = (k == 0) ? $urandom() : ~en;
            apb(1'b1, AXEV_OFS_EVT_ENABLE, en);
            apb(1'b0, AXEV_OFS_EVT_ENABLE, '0);
            chk("enable readback", en & 32'h0007ffff, rd);
            for (int i = 0; i < 27; i++) begin
                pat = (i < 19) ? 19'(1 << i) : 19'($urandom());
                ev <= pat;
                @(posedge clk);
                ev <= '0;
                @(negedge clk);
                chk("event cause", 32'(en[18:0] & pat), 32'(cause));
                chk("event irq", 32'(|(en[18:0] & pat)), 32'(irq));
                @(posedge clk);
            end
        end
        $display("test events done");
        for (int t = 0; t < 5; t++) begin
            apb(1'b1, AXEV_OFS_ENV_FIVE, ($urandom() & 32'hffffbfff) | (32'(t >= 3) << 14));
            apb(1'b0, AXEV_OFS_ENV_FIVE, '0);
            chk("env five", 32'(t >= 3) << 14, rd);
            cmd <= $urandom();
            mech <= $urandom();
            gen <= $urandom();
            defl <= (t == 0) ? 16'h8000 : 16'($urandom());
            spd <= 16'($urandom()) | 16'h0001;
            moving <= (t == 3);
            @(posedge clk);
            latch_trigger_input <= (t % 3 == 0);
            origin_input <= (t % 3 == 1);
            lcmd <= (t % 3 == 2);
            expq = '{cmd, mech, defl_exp(t, defl, spd), gen};
            @(posedge clk);
            {latch_trigger_input, origin_input, lcmd} <= 3'b000;
            {cmd, mech, gen, defl, spd} <= ~{cmd, mech, gen, defl, spd};
            apb(1'b1, AXEV_OFS_CMD_LATCH, $urandom());
            for (int j = 0; j < 4; j++) begin
                apb(1'b0, 8'(4 + 4 * j), '0);
                chk("latch", expq[j], rd);
            end
        end
        $display("test latches done");
        rst <= 1'b1;
        @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        for (int j = 0; j < 5; j++) begin
            apb(1'b0, 8'(4 * j), '0);
            chk("reset again", 32'h00000000, rd);
        end
        clken <= 1'b0;
        latch_trigger_input <= 1'b1;
        apb(1'b1, AXEV_OFS_EVT_ENABLE, 32'h0007ffff);
        latch_trigger_input <= 1'b0;
        clken <= 1'b1;
        apb(1'b0, AXEV_OFS_EVT_ENABLE, '0);
        chk("frozen enable", 32'h00000000, rd);
        apb(1'b0, AXEV_OFS_CMD_LATCH, '0);
        chk("frozen latch", 32'h00000000, rd);
        $display("test reset and freeze done");
        for (int i = 0; i < 8; i++) begin
            op <= 4'(i);
            {dir, plus_slowdown_latched, minus_slowdown_latched, pfc, pfm, mon} <= 20'($urandom());
            apb(1'b0, AXEV_OFS_EXT_STATUS, '0);
            chk("status", {8'h00, minus_slowdown_latched, plus_slowdown_latched, pfm, pfc, mon, dir, op}, rd);
        end
        $display("test status done");
        apb(1'b1, 8'h1c, 32'hffffffff);
        chk("unmapped error", 32'h00000001, 32'(serr));
        apb(1'b0, 8'h1c, '0);
        chk("unmapped read", 32'h00000000, rd);
        $display("test unmapped done");
        test_done();
    end
endmodule
`default_nettype wire
